// [design/dcs_regs.svh]
// register offsets, field positions and reset values of the dma channel block
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// ************
// register byte offsets
// ************
`define DCS_OFS_INT       8'h00
`define DCS_OFS_SSA       8'h04
`define DCS_OFS_DSA       8'h08
`define DCS_OFS_SSIZ      8'h0c
`define DCS_OFS_DSIZ      8'h10
`define DCS_OFS_CSIZ      8'h14
`define DCS_OFS_ECON      8'h18
`define DCS_OFS_CTRL      8'h1c
`define DCS_OFS_SPTR      8'h20
`define DCS_OFS_DPTR      8'h24
`define DCS_OFS_CPTR      8'h28

// ************
// field positions
// ************
`define DCS_IE_HI         23
`define DCS_IE_LO         16
`define DCS_IF_HI         7
`define DCS_IF_LO         0
`define DCS_F_SRC_DONE    7
`define DCS_F_SRC_HALF    6
`define DCS_F_DST_DONE    5
`define DCS_F_DST_HALF    4
`define DCS_F_BLOCK       3
`define DCS_F_CELL        2
`define DCS_F_ABORT       1
`define DCS_F_ADDR_ERR    0
`define DCS_AIRQ_HI       23
`define DCS_AIRQ_LO       16
`define DCS_AIRQ_EN_BIT   3
`define DCS_SIZE_HI       7
`define DCS_CTL_EN_BIT    0
`define DCS_CTL_START_BIT 1
`define DCS_CTL_BUSY_BIT  2

// ************
// reset values and pointer unit indices
// ************
`define DCS_AIRQ_RST      8'hff
`define DCS_SIZE_RST      8'h00
`define DCS_ADDR_RST      32'h0000_0000
`define DCS_WORD_ZERO     32'h0000_0000
`define DCS_PU_SRC        0
`define DCS_PU_DST        1
`define DCS_PU_CELL       2
`define DCS_PU_BLK        3
`define DCS_PU_NUM        4

`endif

// [design/dcs_pkg.sv]
// types shared by the dma channel modules
package dcs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_MOVE = 3'b100
    } dcs_state_t;
endpackage

// [design/dcs_ptr_if.sv]
// byte pointer bundle between the channel and one pointer unit
`timescale 1ns/1ns
interface dcs_ptr_if #(
    parameter int W = 8
);
    logic [W-1:0] size;
    logic         step;
    logic         clr;
    logic [W-1:0] ptr;
    logic         at_end;
    logic         at_half;
    modport unit (input size, input step, input clr, output ptr, output at_end, output at_half);
    modport user (output size, output step, output clr, input ptr, input at_end, input at_half);
endinterface

// [design/dcs_ptr_unit.sv]
// byte pointer with end and midpoint detection, size code zero means full span
`timescale 1ns/1ns
module dcs_ptr_unit #(
    parameter int W = 8
) (
    input  wire logic clock_in,
    input  wire logic rstn_in,
    dcs_ptr_if.unit   pi
);
    logic [W:0] cnt_r;
    logic [W:0] span;
    logic [W:0] cnt_inc;
    logic       end_hit;

    // ************
    // size decode and compare
    // ************
    always_comb begin
        span    = (pi.size == '0) ? {1'b1, {W{1'b0}}} : {1'b0, pi.size};
        cnt_inc = cnt_r + {{W{1'b0}}, 1'b1};
    end

    assign end_hit    = pi.step && (cnt_inc == span);
    assign pi.at_end  = end_hit;
    assign pi.at_half = pi.step && (cnt_inc == (span >> 1));
    assign pi.ptr     = cnt_r[W-1:0];

    // ************
    // counter, wraps to zero on reaching the span
    // ************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_r <= '0;
        end else if (pi.clr) begin
            cnt_r <= '0;
        end else if (pi.step) begin
            cnt_r <= end_hit ? '0 : cnt_inc;
        end
    end
endmodule

// [design/dcs_flag_unit.sv]
// sticky interrupt flags with enables and one combined request
`timescale 1ns/1ns
module dcs_flag_unit #(
    parameter int N = 8
) (
    input  wire logic         clock_in,
    input  wire logic         rstn_in,
    input  wire logic [N-1:0] set_in,
    input  wire logic         wr_in,
    input  wire logic [N-1:0] ie_wdata_in,
    input  wire logic [N-1:0] flag_wdata_in,
    output logic      [N-1:0] ie_out,
    output logic      [N-1:0] flag_out,
    output logic              irq_out
);
    logic [N-1:0] ie_r;
    logic [N-1:0] flag_r;
    logic [N-1:0] ie_nxt;
    logic [N-1:0] flag_nxt;
    logic         irq_r;

    // ************
    // per bit storage, a hardware set beats a software clear
    // ************
    generate
        for (genvar i = 0; i < N; i++) begin : g_bit
            assign ie_nxt[i]   = wr_in ? ie_wdata_in[i] : ie_r[i];
            assign flag_nxt[i] = set_in[i] | (wr_in ? flag_wdata_in[i] : flag_r[i]);
            always_ff @(posedge clock_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    ie_r[i]   <= 1'b0;
                    flag_r[i] <= 1'b0;
                end else begin
                    ie_r[i]   <= ie_nxt[i];
                    flag_r[i] <= flag_nxt[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flag_nxt & ie_nxt);
        end
    end

    assign ie_out   = ie_r;
    assign flag_out = flag_r;
    assign irq_out  = irq_r;
endmodule

// [design/dcs_channel.sv]
// dma channel: setup registers, byte mover, pointers, abort match and interrupt flags
`timescale 1ns/1ns
`include "dcs_regs.svh"
// ************
// Functional notes
// - matching abort irq aborts only when enabled
// - eight interrupt enables in bits 23..16
// - eight matching flags in bits 7..0
// - source pointer reaching size sets source done
// - source pointer at half size sets flag
// - destination pointer reaching size sets done
// - destination pointer at half size sets flag
// - larger size moved or pattern sets block
// - each cell of bytes sets cell flag
// - abort by matching irq sets abort flag
// - invalid source or destination sets error flag
// - source size zero means 256 bytes
// - destination size zero means 256 bytes
// - cell size bytes per event, zero 256
// ************
module dcs_channel #(
    parameter int AW = 8
) (
    input  wire logic          clock_in,
    input  wire logic          rstn_in,
    input  wire logic          psel_in,
    input  wire logic          penable_in,
    input  wire logic          pwrite_in,
    input  wire logic [AW-1:0] paddr_in,
    input  wire logic [31:0]   pwdata_in,
    output logic      [31:0]   prdata_out,
    output logic               pready_out,
    output logic               pslverr_out,
    input  wire logic          irq_valid_in,
    input  wire logic [7:0]    irq_num_in,
    input  wire logic          pattern_match_in,
    output logic               bus_req_out,
    output logic      [31:0]   bus_src_addr_out,
    output logic      [31:0]   bus_dst_addr_out,
    input  wire logic          bus_ack_in,
    input  wire logic          bus_err_in,
    output logic               irq_out
);
    // ************
    // declarations
    // ************
    logic [31:0]         src_start_addr_r;
    logic [31:0]         dst_start_addr_r;
    logic [7:0]          src_size_r;
    logic [7:0]          dst_size_r;
    logic [7:0]          cell_size_r;
    logic [7:0]          abort_irq_number_r;
    logic                abort_irq_enable_r;
    logic                chan_en_r;
    logic                start_r;
    dcs_pkg::dcs_state_t state_r;
    logic                bus_req_r;
    logic [31:0]         bus_src_addr_r;
    logic [31:0]         bus_dst_addr_r;
    logic [31:0]         prdata_r;
    logic                pready_r;
    logic                pslverr_r;

    logic                setup_phase;
    logic                wr_access;
    logic                wr_int;
    logic [31:0]         rd_word;
    logic                addr_hit;
    logic                abort_hit;
    logic                ack_ok;
    logic                ack_err;
    logic                step;
    logic                clr_ptr;
    logic [7:0]          blk_size;
    logic [7:0]          size_sel [`DCS_PU_NUM];
    logic [7:0]          ptr_val  [`DCS_PU_NUM];
    logic [`DCS_PU_NUM-1:0] at_end;
    logic [`DCS_PU_NUM-1:0] at_half;
    logic [7:0]          flag_set;
    logic [7:0]          ie_val;
    logic [7:0]          flag_val;
    logic                irq_val;

    // ************
    // apb decode
    // ************
    assign setup_phase = psel_in && !penable_in;
    // a write lands only at the edge that completes the access phase
    assign wr_access   = psel_in && penable_in && pwrite_in && pready_r;
    assign wr_int      = wr_access && (paddr_in == `DCS_OFS_INT);

    always_comb begin
        rd_word  = `DCS_WORD_ZERO;
        addr_hit = 1'b1;
        case (paddr_in)
            `DCS_OFS_INT: begin
                rd_word[`DCS_IE_HI:`DCS_IE_LO] = ie_val;
                rd_word[`DCS_IF_HI:`DCS_IF_LO] = flag_val;
            end
            `DCS_OFS_SSA: begin
                rd_word = src_start_addr_r;
            end
            `DCS_OFS_DSA: begin
                rd_word = dst_start_addr_r;
            end
            `DCS_OFS_SSIZ: begin
                rd_word[`DCS_SIZE_HI:0] = src_size_r;
            end
            `DCS_OFS_DSIZ: begin
                rd_word[`DCS_SIZE_HI:0] = dst_size_r;
            end
            `DCS_OFS_CSIZ: begin
                rd_word[`DCS_SIZE_HI:0] = cell_size_r;
            end
            `DCS_OFS_ECON: begin
                rd_word[`DCS_AIRQ_HI:`DCS_AIRQ_LO] = abort_irq_number_r;
                rd_word[`DCS_AIRQ_EN_BIT]          = abort_irq_enable_r;
            end
            `DCS_OFS_CTRL: begin
                rd_word[`DCS_CTL_EN_BIT]   = chan_en_r;
                rd_word[`DCS_CTL_BUSY_BIT] = (state_r != dcs_pkg::ST_IDLE);
            end
            `DCS_OFS_SPTR: begin
                rd_word[`DCS_SIZE_HI:0] = ptr_val[`DCS_PU_SRC];
            end
            `DCS_OFS_DPTR: begin
                rd_word[`DCS_SIZE_HI:0] = ptr_val[`DCS_PU_DST];
            end
            `DCS_OFS_CPTR: begin
                rd_word[`DCS_SIZE_HI:0] = ptr_val[`DCS_PU_CELL];
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ************
    // apb answer, zero wait: ready in the first access cycle
    // ************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `DCS_WORD_ZERO;
        end else begin
            pready_r  <= setup_phase;
            pslverr_r <= setup_phase && !addr_hit;
            if (setup_phase) begin
                prdata_r <= (pwrite_in || !addr_hit) ? `DCS_WORD_ZERO : rd_word;
            end
        end
    end

    // ************
    // setup registers, reserved bits are dropped on write
    // ************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_start_addr_r   <= `DCS_ADDR_RST;
            dst_start_addr_r   <= `DCS_ADDR_RST;
            src_size_r         <= `DCS_SIZE_RST;
            dst_size_r         <= `DCS_SIZE_RST;
            cell_size_r        <= `DCS_SIZE_RST;
            abort_irq_number_r <= `DCS_AIRQ_RST;
            abort_irq_enable_r <= 1'b0;
            chan_en_r          <= 1'b0;
        end else if (wr_access) begin
            case (paddr_in)
                `DCS_OFS_SSA: begin
                    src_start_addr_r <= pwdata_in;
                end
                `DCS_OFS_DSA: begin
                    dst_start_addr_r <= pwdata_in;
                end
                `DCS_OFS_SSIZ: begin
                    src_size_r <= pwdata_in[`DCS_SIZE_HI:0];
                end
                `DCS_OFS_DSIZ: begin
                    dst_size_r <= pwdata_in[`DCS_SIZE_HI:0];
                end
                `DCS_OFS_CSIZ: begin
                    cell_size_r <= pwdata_in[`DCS_SIZE_HI:0];
                end
                `DCS_OFS_ECON: begin
                    abort_irq_number_r <= pwdata_in[`DCS_AIRQ_HI:`DCS_AIRQ_LO];
                    abort_irq_enable_r <= pwdata_in[`DCS_AIRQ_EN_BIT];
                end
                `DCS_OFS_CTRL: begin
                    chan_en_r <= pwdata_in[`DCS_CTL_EN_BIT];
                end
                default: begin
                    chan_en_r <= chan_en_r;
                end
            endcase
        end
    end

    // start is a write-one pulse; it reads back as zero
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            start_r <= 1'b0;
        end else begin
            start_r <= wr_access && (paddr_in == `DCS_OFS_CTRL)
                       && pwdata_in[`DCS_CTL_START_BIT];
        end
    end

    // ************
    // abort match and bus answer qualifiers
    // ************
    assign abort_hit = irq_valid_in && abort_irq_enable_r && chan_en_r
                       && (irq_num_in == abort_irq_number_r);
    assign ack_ok    = (state_r == dcs_pkg::ST_MOVE) && bus_ack_in && !bus_err_in && !abort_hit;
    assign ack_err   = (state_r == dcs_pkg::ST_MOVE) && bus_ack_in && bus_err_in;
    assign step      = ack_ok;
    // an abort or a bad address throws away the partial block
    assign clr_ptr   = abort_hit || ack_err || !chan_en_r;

    // ************
    // mover state
    // ************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= dcs_pkg::ST_IDLE;
        end else if (abort_hit || !chan_en_r) begin
            state_r <= dcs_pkg::ST_IDLE;
        end else begin
            case (state_r)
                dcs_pkg::ST_IDLE: begin
                    if (start_r) begin
                        state_r <= dcs_pkg::ST_LOAD;
                    end
                end
                dcs_pkg::ST_LOAD: begin
                    state_r <= dcs_pkg::ST_MOVE;
                end
                dcs_pkg::ST_MOVE: begin
                    if (ack_err) begin
                        state_r <= dcs_pkg::ST_IDLE;
                    end else if (ack_ok) begin
                        // one cell per start event, or the block ran out
                        if (at_end[`DCS_PU_CELL] || at_end[`DCS_PU_BLK]) begin
                            state_r <= dcs_pkg::ST_IDLE;
                        end else begin
                            state_r <= dcs_pkg::ST_LOAD;
                        end
                    end
                end
                default: begin
                    state_r <= dcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************
    // bus request and byte addresses
    // ************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_req_r <= 1'b0;
        end else if (abort_hit || !chan_en_r) begin
            bus_req_r <= 1'b0;
        end else if (state_r == dcs_pkg::ST_LOAD) begin
            bus_req_r <= 1'b1;
        end else if (bus_ack_in) begin
            bus_req_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_src_addr_r <= `DCS_ADDR_RST;
            bus_dst_addr_r <= `DCS_ADDR_RST;
        end else if (state_r == dcs_pkg::ST_LOAD) begin
            bus_src_addr_r <= src_start_addr_r + {24'h00_0000, ptr_val[`DCS_PU_SRC]};
            bus_dst_addr_r <= dst_start_addr_r + {24'h00_0000, ptr_val[`DCS_PU_DST]};
        end
    end

    // ************
    // pointer units: source, destination, cell, block
    // ************
    // block span is the larger size; a zero code already stands for the largest
    assign blk_size = (src_size_r == `DCS_SIZE_RST || dst_size_r == `DCS_SIZE_RST) ?
                      `DCS_SIZE_RST :
                      ((src_size_r > dst_size_r) ? src_size_r : dst_size_r);
    assign size_sel[`DCS_PU_SRC]  = src_size_r;
    assign size_sel[`DCS_PU_DST]  = dst_size_r;
    assign size_sel[`DCS_PU_CELL] = cell_size_r;
    assign size_sel[`DCS_PU_BLK]  = blk_size;

    dcs_ptr_if #(.W(8)) pif [`DCS_PU_NUM] ();

    generate
        for (genvar i = 0; i < `DCS_PU_NUM; i++) begin : g_ptr
            assign pif[i].size = size_sel[i];
            assign pif[i].step = step;
            assign pif[i].clr  = clr_ptr;
            assign ptr_val[i]  = pif[i].ptr;
            assign at_end[i]   = pif[i].at_end;
            assign at_half[i]  = pif[i].at_half;
            dcs_ptr_unit #(
                .W (8)
            ) u_ptr (
                .clock_in (clock_in),
                .rstn_in  (rstn_in),
                .pi       (pif[i])
            );
        end
    endgenerate

    // ************
    // interrupt flags
    // ************
    always_comb begin
        flag_set                  = 8'h00;
        flag_set[`DCS_F_SRC_DONE] = at_end[`DCS_PU_SRC];
        flag_set[`DCS_F_SRC_HALF] = at_half[`DCS_PU_SRC];
        flag_set[`DCS_F_DST_DONE] = at_end[`DCS_PU_DST];
        flag_set[`DCS_F_DST_HALF] = at_half[`DCS_PU_DST];
        flag_set[`DCS_F_BLOCK]    = at_end[`DCS_PU_BLK] || pattern_match_in;
        flag_set[`DCS_F_CELL]     = at_end[`DCS_PU_CELL];
        flag_set[`DCS_F_ABORT]    = abort_hit;
        flag_set[`DCS_F_ADDR_ERR] = ack_err;
    end

    dcs_flag_unit #(
        .N (8)
    ) u_flags (
        .clock_in      (clock_in),
        .rstn_in       (rstn_in),
        .set_in        (flag_set),
        .wr_in         (wr_int),
        .ie_wdata_in   (pwdata_in[`DCS_IE_HI:`DCS_IE_LO]),
        .flag_wdata_in (pwdata_in[`DCS_IF_HI:`DCS_IF_LO]),
        .ie_out        (ie_val),
        .flag_out      (flag_val),
        .irq_out       (irq_val)
    );

    // ************
    // outputs
    // ************
    assign prdata_out       = prdata_r;
    assign pready_out       = pready_r;
    assign pslverr_out      = pslverr_r;
    assign bus_req_out      = bus_req_r;
    assign bus_src_addr_out = bus_src_addr_r;
    assign bus_dst_addr_out = bus_dst_addr_r;
    assign irq_out          = irq_val;
endmodule

// [testbench/dcs_channel_properties.sv]
// concurrent checks on the ports of the dma channel
`timescale 1ns/1ns
module dcs_channel_properties (
    input wire logic        clock_in,
    input wire logic        rstn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        irq_valid_in,
    input wire logic        pattern_match_in,
    input wire logic        bus_req_out,
    input wire logic [31:0] bus_src_addr_out,
    input wire logic        bus_ack_in,
    input wire logic        bus_err_in,
    input wire logic        irq_out
);
    logic ev;
    logic wr_acc;
    // causes that may raise a flag
    assign wr_acc = psel_in & penable_in & pwrite_in;
    assign ev = bus_ack_in | irq_valid_in | pattern_match_in | wr_acc;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    AST_RD_READY: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready in access cycle");
    AST_UNMAPPED: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_REQ_HOLD: assert property (bus_req_out && !bus_ack_in && !irq_valid_in && !$past(wr_acc)
        |=> bus_req_out && $stable(bus_src_addr_out))
        else $error("byte request dropped before ack");
    AST_REQ_DROP: assert property (bus_req_out && bus_ack_in |=> !bus_req_out)
        else $error("request held after ack");
    AST_ERR_STOP: assert property (bus_req_out && bus_ack_in && bus_err_in |=> !bus_req_out [*3])
        else $error("moving on after address error");
    AST_SRC_STEP: assert property (bus_req_out && bus_ack_in && !bus_err_in ##1 !bus_req_out
        ##1 bus_req_out |-> bus_src_addr_out == $past(bus_src_addr_out, 2) + 32'h1)
        else $error("source address did not step by one");
    AST_IRQ_RISE: assert property ($rose(irq_out) |-> $past(ev) || $past(ev, 2))
        else $error("request rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("request fell without a write");
    cover property (bus_ack_in && bus_err_in);
    cover property (irq_valid_in ##1 $fell(bus_req_out));
    cover property (pslverr_out);
endmodule

// [testbench/dcs_bus_model.sv]
// behavioural system bus memory answering byte moves of the channel
`timescale 1ns/1ns
module dcs_bus_model (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic        req_in,
    input  wire logic [31:0] src_in,
    input  wire logic [31:0] dst_in,
    input  wire logic [7:0]  lat_in,
    input  wire logic        err_en_in,
    output logic             ack_out,
    output logic             err_out,
    output logic      [31:0] last_src_out,
    output logic      [31:0] last_dst_out
);
    int cnt;
    // lat_in stalls each byte so that slow memory is exercised too
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt <= 0;
            ack_out <= 1'b0;
            err_out <= 1'b0;
            last_src_out <= 32'h0;
            last_dst_out <= 32'h0;
        end else if (req_in && !ack_out && cnt >= lat_in) begin
            ack_out <= 1'b1;
            err_out <= err_en_in;
            last_src_out <= src_in;
            last_dst_out <= dst_in;
            cnt <= 0;
        end else begin
            ack_out <= 1'b0;
            err_out <= 1'b0;
            cnt <= (req_in && !ack_out) ? cnt + 1 : 0;
        end
    end
endmodule

// [testbench/dcs_channel_test.sv]
// self-checking bench of the dma channel
`timescale 1ns/1ns
`include "dcs_regs.svh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module dcs_channel_test;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, irq_num = 8'h00, lat = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, src_a, dst_a, last_src, last_dst, q;
    logic irq_valid = 1'b0, pat = 1'b0, err_en = 1'b0, pready, pslverr, req, ack, berr, irq, slv;
    int err_total = 0, check_count = 0, cyc = 0;
    dcs_channel i_dcs_channel (.clock_in(clk), .rstn_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .irq_valid_in(irq_valid), .irq_num_in(irq_num), .pattern_match_in(pat),
        .bus_req_out(req), .bus_src_addr_out(src_a), .bus_dst_addr_out(dst_a),
        .bus_ack_in(ack), .bus_err_in(berr), .irq_out(irq));
    dcs_bus_model i_dcs_bus_model (.clock_in(clk), .rstn_in(rst_n), .req_in(req), .src_in(src_a),
        .dst_in(dst_a), .lat_in(lat), .err_en_in(err_en), .ack_out(ack), .err_out(berr),
        .last_src_out(last_src), .last_dst_out(last_dst));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input int b);
        for (int n = 0; n < 400; n++) begin
            bus(1'b0, `DCS_OFS_INT, 32'h0);
            if (q[b] === 1'b1) break;
        end
    endtask
    task automatic go(input logic [7:0] s, input logic [7:0] d, input logic [7:0] c);
        bus(1'b1, `DCS_OFS_CTRL, 32'h0);
        bus(1'b1, `DCS_OFS_INT, 32'h00ff_0000);
        bus(1'b1, `DCS_OFS_SSIZ, {24'h0, s});
        bus(1'b1, `DCS_OFS_DSIZ, {24'h0, d});
        bus(1'b1, `DCS_OFS_CSIZ, {24'h0, c});
        bus(1'b1, `DCS_OFS_CTRL, 32'h0000_0003);
    endtask
    task automatic pulse(input logic [7:0] n);
        irq_valid <= 1'b1;
        irq_num <= n;
        @(posedge clk);
        irq_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset();
        bus(1'b0, `DCS_OFS_INT, 32'h0);
        `CHK("int reset", 32'h0, q)
        bus(1'b0, `DCS_OFS_ECON, 32'h0);
        `CHK("abort number reset", 8'hff, q[23:16])
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped slverr", 1'b1, slv)
        $display("end reset test");
    endtask
    task automatic t_regs();
        bus(1'b1, `DCS_OFS_SSA, 32'h1000_0000);
        bus(1'b1, `DCS_OFS_DSA, 32'h2000_0000);
        bus(1'b0, `DCS_OFS_DSA, 32'h0);
        `CHK("dest start", 32'h2000_0000, q)
        bus(1'b1, `DCS_OFS_INT, 32'h0000_0001);
        bus(1'b0, `DCS_OFS_SSA, 32'h0);
        `CHK("source start", 32'h1000_0000, q)
        `CHK("flag without enable", 1'b0, irq)
        bus(1'b1, `DCS_OFS_INT, 32'h0001_0001);
        bus(1'b0, `DCS_OFS_INT, 32'h0);
        `CHK("int readback", 32'h0001_0001, q)
        `CHK("enabled request", 1'b1, irq)
        bus(1'b1, `DCS_OFS_INT, 32'h00ff_0000);
        bus(1'b0, `DCS_OFS_INT, 32'h0);
        `CHK("flag cleared", 1'b0, irq)
        $display("end register test");
    endtask
    task automatic t_small();
        lat <= 8'h02;
        go(8'h08, 8'h02, 8'h04);
        poll(`DCS_F_CELL);
        `CHK("small flags", 32'h00ff_0074, q)
        `CHK("last source", 32'h1000_0003, last_src)
        `CHK("dest wrap", 32'h2000_0001, last_dst)
        $display("end small cell test");
    endtask
    task automatic t_full();
        lat <= 8'h00;
        go(8'h00, 8'h00, 8'h00);
        poll(`DCS_F_CELL);
        `CHK("full flags", 32'h00ff_00fc, q)
        `CHK("source span", 32'h1000_00ff, last_src)
        `CHK("dest span", 32'h2000_00ff, last_dst)
        $display("end full span test");
    endtask
    task automatic t_abort();
        lat <= 8'h28;
        bus(1'b1, `DCS_OFS_ECON, 32'h0021_0000);
        go(8'h10, 8'h10, 8'h08);
        repeat (4) @(posedge clk);
        pulse(8'h21);
        `CHK("abort disabled", 1'b1, req)
        bus(1'b1, `DCS_OFS_ECON, 32'h0021_0008);
        pulse(8'h20);
        `CHK("other number", 1'b1, req)
        pulse(8'h21);
        `CHK("aborted", 1'b0, req)
        bus(1'b0, `DCS_OFS_INT, 32'h0);
        `CHK("abort flag", 32'h00ff_0002, q)
        $display("end abort test");
    endtask
    task automatic t_err_pat();
        lat <= 8'h01;
        err_en <= 1'b1;
        go(8'h10, 8'h10, 8'h08);
        poll(`DCS_F_ADDR_ERR);
        `CHK("error flag", 32'h00ff_0001, q)
        err_en <= 1'b0;
        pat <= 1'b1;
        @(posedge clk);
        pat <= 1'b0;
        bus(1'b0, `DCS_OFS_INT, 32'h0);
        `CHK("pattern block", 32'h00ff_0009, q)
        $display("end error and pattern test");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_small();
        t_full();
        t_abort();
        t_err_pat();
        complete_run();
    end
endmodule
bind dcs_channel dcs_channel_properties i_dcs_channel_properties (.*);
